// [rtl/tsv_pkg.sv]
package tsv_pkg;

   // ------------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------------
   localparam int TSV_ADDR_W = 12;   // Byte address bits decoded
   localparam int TSV_DATA_W = 32;   // AHB-Lite data width

   typedef logic [TSV_ADDR_W-1:0] tsv_addr_t;
   typedef logic [TSV_DATA_W-1:0] tsv_word_t;

   // ------------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------------
   localparam tsv_addr_t TSV_OFF_ATTR_A = 12'h5C4;
   localparam tsv_addr_t TSV_OFF_ATTR_B = 12'h5C8;
   localparam tsv_addr_t TSV_OFF_RATIO_NUM = 12'h5CC;
   localparam tsv_addr_t TSV_OFF_TU_LEN = 12'h5D0;
   localparam tsv_addr_t TSV_OFF_RATIO_DEN = 12'h5D4;
   localparam tsv_addr_t TSV_OFF_PIX_WIDTH = 12'h5D8;
   localparam tsv_addr_t TSV_OFF_LANE_WORDS = 12'h5DC;
   localparam tsv_addr_t TSV_OFF_INTERLACE = 12'h5E0;
   localparam tsv_addr_t TSV_OFF_MIN_BYTES = 12'h5E4;
   localparam tsv_addr_t TSV_OFF_FRAC_BYTES = 12'h5E8;
   localparam tsv_addr_t TSV_OFF_LINE_DELAY = 12'h5EC;

   // Payload table window: 0x800 to 0x8FF, byte entries
   localparam tsv_addr_t TSV_TABLE_BASE = 12'h800;
   localparam tsv_addr_t TSV_TABLE_MASK = 12'hF00;
   localparam int TSV_TABLE_DEPTH = 256;
   localparam int TSV_TABLE_IDX_W = 8;
   localparam int TSV_LANES = 4;     // Byte lanes per bus word

   // ------------------------------------------------------------------
   // Field widths and positions
   // ------------------------------------------------------------------
   localparam int TSV_ATTR_W = 8;
   localparam int TSV_RATIO_W = 24;
   localparam int TSV_TU_W = 7;
   localparam int TSV_PIX_W = 3;
   localparam int TSV_MIN_W = 8;
   localparam int TSV_FRAC_W = 10;
   localparam int TSV_DELAY_W = 8;
   localparam int TSV_SYNC_CLK_BIT = 0;   // Synchronous clock flag in byte A
   localparam int TSV_TU_EVEN_BIT = 0;    // Write-ignored bit of unit length
   localparam int TSV_INTERLACE_BIT = 0;
   localparam int TSV_ATTR_B_USED_W = 3;  // Bits 2:0 used, 7:3 reserved

   // ------------------------------------------------------------------
   // Reset values and pixel port codes
   // ------------------------------------------------------------------
   localparam logic [TSV_TU_W-1:0] TSV_TU_RESET = 7'h40;
   localparam logic [TSV_PIX_W-1:0] TSV_PIX_ONE = 3'h1;
   localparam logic [TSV_PIX_W-1:0] TSV_PIX_TWO = 3'h2;
   localparam logic [TSV_PIX_W-1:0] TSV_PIX_FOUR = 3'h4;

   // AHB-Lite encodings
   localparam logic [1:0] TSV_HTRANS_NONSEQ = 2'h2;
   localparam logic TSV_HRESP_OKAY = 1'b0;

endpackage

// [rtl/tsv_reg_if.sv]
`timescale 1ns/1ps
`default_nettype none

// Register access strobes between the bus front end and the bank
interface tsv_reg_if;
   import tsv_pkg::*;
   logic wr_en;        // One-cycle write strobe
   logic rd_en;        // One-cycle read strobe
   tsv_addr_t addr;    // Byte address of the access
   tsv_word_t wdata;   // Write data
   tsv_word_t rdata;   // Read data, valid the cycle after rd_en

   modport front (output wr_en, rd_en, addr, wdata, input rdata);
   modport bank (input wr_en, rd_en, addr, wdata, output rdata);
endinterface

`default_nettype wire

// [rtl/tsv_ahb_front.sv]
`timescale 1ns/1ps
`default_nettype none

// AHB-Lite slave front end: zero wait writes, one wait state reads
module tsv_ahb_front
   import tsv_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave pins
   input wire logic hsel,
   input wire tsv_pkg::tsv_addr_t haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire tsv_pkg::tsv_word_t hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output tsv_pkg::tsv_word_t hrdata,
   // Register side
   tsv_reg_if.front regs
);

   // ------------------------------------------------------------------
   // Address phase capture
   // ------------------------------------------------------------------
   logic dphase_q;     // A data phase is in progress
   logic write_q;      // Its direction
   tsv_addr_t addr_q;  // Its address
   logic rd_done_q;    // Read data already fetched
   wire take_addr = hready & hsel & htrans[1];

   // Only NONSEQ singles are expected; SEQ is treated the same way
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dphase_q <= 1'b0;
         write_q <= 1'b0;
         addr_q <= '0;
      end
      else if (hready)
      begin
         dphase_q <= take_addr;
         write_q <= hwrite;
         addr_q <= haddr;
      end
   end

   // Read takes one wait state so hrdata comes from a flip-flop
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rd_done_q <= 1'b0;
      else
         rd_done_q <= regs.rd_en;
   end

   // ------------------------------------------------------------------
   // Strobes and response
   // ------------------------------------------------------------------
   assign regs.wr_en = dphase_q & write_q;
   assign regs.rd_en = dphase_q & ~write_q & ~rd_done_q;
   assign regs.addr = addr_q;
   assign regs.wdata = hwdata;
   assign hreadyout = ~regs.rd_en;
   assign hresp = TSV_HRESP_OKAY;
   assign hrdata = regs.rdata;

endmodule

`default_nettype wire

// [rtl/tsv_slot_table.sv]
`timescale 1ns/1ps
`default_nettype none

// Virtual channel payload table: byte entries, written a word at a time
module tsv_slot_table
   import tsv_pkg::*;
#(
   parameter int DEPTH = tsv_pkg::TSV_TABLE_DEPTH
)
(
   // Clock
   input wire logic hclk,
   // Write port, one bus word covers four entries
   input wire logic wr_en,
   input wire logic [tsv_pkg::TSV_TABLE_IDX_W-1:0] wr_idx,
   input wire tsv_pkg::tsv_word_t wr_data,
   // Read port for the link encoder
   input wire logic [tsv_pkg::TSV_TABLE_IDX_W-1:0] rd_idx,
   output logic [7:0] rd_data
);

   // No reset on the array: software fills it before enabling streams
   logic [7:0] mem [DEPTH];

   // ------------------------------------------------------------------
   // One write per byte lane
   // ------------------------------------------------------------------
   logic [TSV_TABLE_IDX_W-1:0] lane_idx [TSV_LANES];
   for (genvar g = 0; g < TSV_LANES; g++)
   begin : g_lane
      assign lane_idx[g] = wr_idx + TSV_TABLE_IDX_W'(g);
   end

   // One process owns the array, so it has a single driver
   always_ff @(posedge hclk)
   begin
      if (wr_en)
         for (int i = 0; i < TSV_LANES; i++)
            mem[lane_idx[i]] <= wr_data[8*i +: 8];
   end

   // Registered read toward the encoder
   always_ff @(posedge hclk)
   begin
      rd_data <= mem[rd_idx];
   end

endmodule

`default_nettype wire

// [rtl/tsv_stream4_cfg.sv]
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Stream 4 video configuration bank
// ------------------------------------------------------------------
module tsv_stream4_cfg
   import tsv_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire tsv_pkg::tsv_addr_t haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire tsv_pkg::tsv_word_t hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output tsv_pkg::tsv_word_t hrdata,
   // Clock ratio values computed by the link in asynchronous mode
   input wire logic [tsv_pkg::TSV_RATIO_W-1:0] auto_ratio_num,
   input wire logic [tsv_pkg::TSV_RATIO_W-1:0] auto_ratio_den,
   // Framing logic line start handshake
   input wire logic line_start,
   output logic line_wait_active,
   output logic line_wait_done,
   // Configuration toward the main link encoder
   output logic [tsv_pkg::TSV_ATTR_W-1:0] stream_attr_byte_a,
   output logic [tsv_pkg::TSV_ATTR_W-1:0] stream_attr_byte_b,
   output logic [tsv_pkg::TSV_RATIO_W-1:0] clock_ratio_numerator,
   output logic [tsv_pkg::TSV_RATIO_W-1:0] clock_ratio_denominator,
   output logic [tsv_pkg::TSV_TU_W-1:0] transfer_unit_length,
   output logic [2:0] pixels_per_clock,
   output logic [31:0] lane_word_count,
   output logic unit_interlaced,
   output logic vbid_interlaced,
   output logic [tsv_pkg::TSV_MIN_W-1:0] unit_min_bytes,
   output logic [tsv_pkg::TSV_FRAC_W-1:0] unit_fraction_bytes,
   // Payload table read port
   input wire logic [tsv_pkg::TSV_TABLE_IDX_W-1:0] slot_idx,
   output logic [7:0] slot_data
);

   // ------------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------------
   // Word address match; low two bits are ignored, all transfers are words
   function automatic logic hit(input tsv_addr_t a, input tsv_addr_t off);
      hit = (a[TSV_ADDR_W-1:2] == off[TSV_ADDR_W-1:2]);
   endfunction

   // Pixel port code to one-hot lane select; unknown codes fall back to one
   function automatic logic [2:0] pix_select(input logic [TSV_PIX_W-1:0] code);
      logic [2:0] sel;
      sel = 3'h1;
      if (code == TSV_PIX_TWO)
         sel = 3'h2;
      else if (code == TSV_PIX_FOUR)
         sel = 3'h4;
      pix_select = sel;
   endfunction

   // Hsize is not checked: only whole words are supported
   wire unused_hsize = ^hsize;

   // ------------------------------------------------------------------
   // Bus front end
   // ------------------------------------------------------------------
   tsv_reg_if rif ();

   tsv_ahb_front u_front (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .regs(rif.front)
   );

   // ------------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------------
   logic [TSV_ATTR_W-1:0] attr_a_q;          // Byte A fields
   logic [TSV_ATTR_B_USED_W-1:0] attr_b_q;   // Byte B used bits
   logic [TSV_RATIO_W-1:0] ratio_num_q;      // Software numerator
   logic [TSV_RATIO_W-1:0] ratio_den_q;      // Software denominator
   logic [TSV_TU_W-1:0] tu_len_q;            // Unit length, always even
   logic [TSV_PIX_W-1:0] pix_width_q;        // Pixel port code
   logic [31:0] lane_words_q;                // Per-lane word count
   logic interlace_q;                        // Interlaced source
   logic [TSV_MIN_W-1:0] min_bytes_q;        // Whole bytes per unit
   logic [TSV_FRAC_W-1:0] frac_bytes_q;      // Fraction bytes times 1000
   logic [TSV_DELAY_W-1:0] line_delay_q;     // Line start wait count
   tsv_word_t rdata_q;                       // Read data toward the bus

   // Per-register write strobes
   wire wr = rif.wr_en;
   wire wr_attr_a = wr & hit(rif.addr, TSV_OFF_ATTR_A);
   wire wr_attr_b = wr & hit(rif.addr, TSV_OFF_ATTR_B);
   wire wr_num = wr & hit(rif.addr, TSV_OFF_RATIO_NUM);
   wire wr_tu = wr & hit(rif.addr, TSV_OFF_TU_LEN);
   wire wr_den = wr & hit(rif.addr, TSV_OFF_RATIO_DEN);
   wire wr_pix = wr & hit(rif.addr, TSV_OFF_PIX_WIDTH);
   wire wr_lane = wr & hit(rif.addr, TSV_OFF_LANE_WORDS);
   wire wr_ilace = wr & hit(rif.addr, TSV_OFF_INTERLACE);
   wire wr_min = wr & hit(rif.addr, TSV_OFF_MIN_BYTES);
   wire wr_frac = wr & hit(rif.addr, TSV_OFF_FRAC_BYTES);
   wire wr_delay = wr & hit(rif.addr, TSV_OFF_LINE_DELAY);
   wire in_table = ((rif.addr & TSV_TABLE_MASK) == TSV_TABLE_BASE);
   wire wr_table = wr & in_table;

   // Bit 0 of the unit length is forced low so the size stays even
   wire [TSV_TU_W-1:0] tu_wdata = {rif.wdata[TSV_TU_W-1:1], 1'b0};

   // Format and data bits held as written; byte B keeps only used bits 2:0
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         attr_a_q <= '0;
         attr_b_q <= '0;
         ratio_num_q <= '0;
         ratio_den_q <= '0;
         pix_width_q <= TSV_PIX_ONE;
         lane_words_q <= '0;
      end
      else
      begin
         if (wr_attr_a)
            attr_a_q <= rif.wdata[TSV_ATTR_W-1:0];
         if (wr_attr_b)
            attr_b_q <= rif.wdata[TSV_ATTR_B_USED_W-1:0];
         if (wr_num)
            ratio_num_q <= rif.wdata[TSV_RATIO_W-1:0];
         if (wr_den)
            ratio_den_q <= rif.wdata[TSV_RATIO_W-1:0];
         if (wr_pix)
            pix_width_q <= rif.wdata[TSV_PIX_W-1:0];
         if (wr_lane)
            lane_words_q <= rif.wdata;
      end
   end

   // Transfer unit sizing and timing registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tu_len_q <= TSV_TU_RESET;
         interlace_q <= 1'b0;
         min_bytes_q <= '0;
         frac_bytes_q <= '0;
         line_delay_q <= '0;
      end
      else
      begin
         if (wr_tu)
            tu_len_q <= tu_wdata;
         if (wr_ilace)
            interlace_q <= rif.wdata[TSV_INTERLACE_BIT];
         if (wr_min)
            min_bytes_q <= rif.wdata[TSV_MIN_W-1:0];
         if (wr_frac)
            frac_bytes_q <= rif.wdata[TSV_FRAC_W-1:0];
         if (wr_delay)
            line_delay_q <= rif.wdata[TSV_DELAY_W-1:0];
      end
   end

   // ------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------
   // Software values only: computed ratios are never copied back
   function automatic tsv_word_t read_select(input tsv_addr_t a);
      tsv_word_t v;
      v = '0;
      if (hit(a, TSV_OFF_ATTR_A))
         v = tsv_word_t'(attr_a_q);
      else if (hit(a, TSV_OFF_ATTR_B))
         v = tsv_word_t'(attr_b_q);
      else if (hit(a, TSV_OFF_RATIO_NUM))
         v = tsv_word_t'(ratio_num_q);
      else if (hit(a, TSV_OFF_TU_LEN))
         v = tsv_word_t'(tu_len_q);
      else if (hit(a, TSV_OFF_RATIO_DEN))
         v = tsv_word_t'(ratio_den_q);
      else if (hit(a, TSV_OFF_PIX_WIDTH))
         v = tsv_word_t'(pix_width_q);
      else if (hit(a, TSV_OFF_LANE_WORDS))
         v = lane_words_q;
      else if (hit(a, TSV_OFF_INTERLACE))
         v = tsv_word_t'(interlace_q);
      else if (hit(a, TSV_OFF_MIN_BYTES))
         v = tsv_word_t'(min_bytes_q);
      else if (hit(a, TSV_OFF_FRAC_BYTES))
         v = tsv_word_t'(frac_bytes_q);
      else if (hit(a, TSV_OFF_LINE_DELAY))
         v = tsv_word_t'(line_delay_q);
      read_select = v;
   endfunction

   // Table window and unmapped space read as zero
   // Read at the edge so a value written just before is seen

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rdata_q <= '0;
      else if (rif.rd_en)
         rdata_q <= read_select(rif.addr);
   end

   assign rif.rdata = rdata_q;

   // ------------------------------------------------------------------
   // Payload table
   // ------------------------------------------------------------------
   tsv_slot_table #(
      .DEPTH(TSV_TABLE_DEPTH)
   ) u_table (
      .hclk(hclk),
      .wr_en(wr_table),
      .wr_idx(rif.addr[TSV_TABLE_IDX_W-1:0]),
      .wr_data(rif.wdata),
      .rd_idx(slot_idx),
      .rd_data(slot_data)
   );

   // ------------------------------------------------------------------
   // Clock ratio selection toward the stream
   // ------------------------------------------------------------------
   logic [TSV_RATIO_W-1:0] num_out_q;
   logic [TSV_RATIO_W-1:0] den_out_q;
   wire sync_mode = attr_a_q[TSV_SYNC_CLK_BIT];
   wire [TSV_RATIO_W-1:0] num_sel = sync_mode ? ratio_num_q : auto_ratio_num;
   wire [TSV_RATIO_W-1:0] den_sel = sync_mode ? ratio_den_q : auto_ratio_den;

   // Registered so the encoder sees a glitch-free value on mode change
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         num_out_q <= '0;
         den_out_q <= '0;
      end
      else
      begin
         num_out_q <= num_sel;
         den_out_q <= den_sel;
      end
   end

   // ------------------------------------------------------------------
   // Line start wait
   // ------------------------------------------------------------------
   typedef enum logic [0:0] {
      TSV_WAIT_IDLE = 1'b0,
      TSV_WAIT_COUNT = 1'b1
   } tsv_wait_e;

   tsv_wait_e wait_state_q;
   logic [TSV_DELAY_W-1:0] wait_cnt_q;   // Cycles still to wait
   logic wait_done_q;                    // Done pulse

   // A new line start restarts the wait; a count of zero ends at once from idle, but a restart with zero wraps and waits 256 cycles
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wait_state_q <= TSV_WAIT_IDLE;
         wait_cnt_q <= '0;
         wait_done_q <= 1'b0;
      end
      else
      begin
         wait_done_q <= 1'b0;
         case (wait_state_q)
            TSV_WAIT_IDLE:
            begin
               if (line_start)
               begin
                  if (line_delay_q == '0)
                     wait_done_q <= 1'b1;
                  else
                  begin
                     wait_cnt_q <= line_delay_q;
                     wait_state_q <= TSV_WAIT_COUNT;
                  end
               end
            end
            TSV_WAIT_COUNT:
            begin
               if (line_start)
                  wait_cnt_q <= line_delay_q;
               else if (wait_cnt_q == TSV_DELAY_W'(1))
               begin
                  wait_cnt_q <= '0;
                  wait_done_q <= 1'b1;
                  wait_state_q <= TSV_WAIT_IDLE;
               end
               else
                  wait_cnt_q <= wait_cnt_q - TSV_DELAY_W'(1);
            end
            default:
               wait_state_q <= TSV_WAIT_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign line_wait_active = (wait_state_q == TSV_WAIT_COUNT);
   assign line_wait_done = wait_done_q;
   assign stream_attr_byte_a = attr_a_q;
   assign stream_attr_byte_b = TSV_ATTR_W'(attr_b_q);
   assign clock_ratio_numerator = num_out_q;
   assign clock_ratio_denominator = den_out_q;
   assign transfer_unit_length = tu_len_q;
   assign pixels_per_clock = pix_select(pix_width_q);
   assign lane_word_count = lane_words_q;
   assign unit_interlaced = interlace_q;
   assign vbid_interlaced = interlace_q;
   assign unit_min_bytes = min_bytes_q;
   assign unit_fraction_bytes = frac_bytes_q;

endmodule

`default_nettype wire

// [tb/tsv_cfg_asserts.sv]
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Port checker for the stream 4 configuration bank
// ------------------------------------------------------------------
module tsv_cfg_asserts
   import tsv_pkg::*;
(
   // Clock, reset and bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // Link and framing side
   input wire logic [23:0] auto_ratio_num,
   input wire logic [23:0] auto_ratio_den,
   input wire logic line_start,
   input wire logic line_wait_active,
   input wire logic line_wait_done,
   input wire logic [7:0] stream_attr_byte_a,
   input wire logic [7:0] stream_attr_byte_b,
   input wire logic [23:0] clock_ratio_numerator,
   input wire logic [23:0] clock_ratio_denominator,
   input wire logic [6:0] transfer_unit_length,
   input wire logic [2:0] pixels_per_clock,
   input wire logic unit_interlaced,
   input wire logic vbid_interlaced
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Address phase accepted by the slave
   wire take = hsel && hready && htrans[1];
   // A read stalls exactly one cycle
   sequence read_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   wr_zero_wait_a: assert property (take && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   rd_one_wait_a: assert property (take && !hwrite |=> read_wait)
      else $error("read wait state wrong");
   resp_okay_a: assert property (hresp == TSV_HRESP_OKAY)
      else $error("error response seen");
   tu_reset_a: assert property ($rose(hresetn) |-> transfer_unit_length == TSV_TU_RESET)
      else $error("unit length reset wrong");
   tu_even_a: assert property (transfer_unit_length[0] == 1'b0)
      else $error("unit length odd");
   attr_b_rsvd_a: assert property (stream_attr_byte_b[7:3] == 5'h00)
      else $error("attribute byte b reserved bits set");
   pix_onehot_a: assert property ($onehot(pixels_per_clock))
      else $error("pixel width not one hot");
   num_async_a: assert property ($past(hresetn) && !$past(stream_attr_byte_a[0])
      |-> clock_ratio_numerator == $past(auto_ratio_num)) else $error("numerator not link value");
   den_async_a: assert property ($past(hresetn) && !$past(stream_attr_byte_a[0])
      |-> clock_ratio_denominator == $past(auto_ratio_den)) else $error("denominator not link value");
   interlace_pair_a: assert property (unit_interlaced == vbid_interlaced)
      else $error("interlace marks differ");
   wait_start_a: assert property (line_start |=> line_wait_active || line_wait_done)
      else $error("line start ignored");
   wait_end_a: assert property ($fell(line_wait_active) |-> line_wait_done)
      else $error("wait ended without done");
endmodule

bind tsv_stream4_cfg tsv_cfg_asserts u_tsv_cfg_asserts (.*);

`default_nettype wire

// [tb/tsv_frame_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Framing and link side: line starts and link-computed ratio values
module tsv_frame_model
(
   // Clock
   input wire logic hclk,
   // Outputs toward the bank
   output logic line_start,
   output logic [tsv_pkg::TSV_RATIO_W-1:0] auto_num,
   output logic [tsv_pkg::TSV_RATIO_W-1:0] auto_den
);
   initial
   begin
      line_start = 1'b0;
      auto_num = 24'h000100;
      auto_den = 24'hFFF000;
   end
   // Values move every cycle so a stale or wrong select shows at once
   always @(posedge hclk)
   begin
      auto_num <= auto_num + 24'h000003;
      auto_den <= auto_den - 24'h000005;
   end
   // One-cycle line start pulse
   task send_line();
      @(posedge hclk);
      line_start <= 1'b1;
      @(posedge hclk);
      line_start <= 1'b0;
   endtask
endmodule

`default_nettype wire

// [tb/tb_tsv_stream4_cfg.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_tsv_stream4_cfg;
   import tsv_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic line_start, line_wait_active, line_wait_done, unit_interlaced, vbid_interlaced;
   logic [1:0] htrans;
   logic [2:0] hsize, pixels_per_clock;
   tsv_addr_t haddr;
   tsv_word_t hwdata, hrdata, rd;
   logic [23:0] auto_ratio_num, auto_ratio_den, clock_ratio_numerator, clock_ratio_denominator;
   logic [7:0] stream_attr_byte_a, stream_attr_byte_b, unit_min_bytes, slot_idx, slot_data;
   logic [6:0] transfer_unit_length;
   logic [31:0] lane_word_count;
   logic [9:0] unit_fraction_bytes;
   int error_cnt, cmp_count, n;
   // Register table: offsets, reset values, writable bits
   localparam tsv_addr_t OFS [11] = '{TSV_OFF_ATTR_A, TSV_OFF_ATTR_B, TSV_OFF_RATIO_NUM,
      TSV_OFF_TU_LEN, TSV_OFF_RATIO_DEN, TSV_OFF_PIX_WIDTH, TSV_OFF_LANE_WORDS,
      TSV_OFF_INTERLACE, TSV_OFF_MIN_BYTES, TSV_OFF_FRAC_BYTES, TSV_OFF_LINE_DELAY};
   localparam tsv_word_t RST [11] = '{32'h0, 32'h0, 32'h0, 32'h40, 32'h0, 32'h1, 32'h0,
      32'h0, 32'h0, 32'h0, 32'h0};
   localparam tsv_word_t MSK [11] = '{32'hFF, 32'h7, 32'hFFFFFF, 32'h7E, 32'hFFFFFF, 32'h7,
      32'hFFFFFFFF, 32'h1, 32'hFF, 32'h3FF, 32'hFF};
   assign hready = hreadyout;
   tsv_stream4_cfg u_tsv_stream4_cfg (.*);
   tsv_frame_model u_tsv_frame_model (.hclk(hclk), .line_start(line_start),
      .auto_num(auto_ratio_num), .auto_den(auto_ratio_den));
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   // One single AHB transfer; waits on the slave's own ready
   task ahb(input logic w, input tsv_addr_t a, input tsv_word_t d);
      @(posedge hclk);
      hsel <= 1'b1; htrans <= TSV_HTRANS_NONSEQ; haddr <= a; hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task chk(input tsv_word_t got, input tsv_word_t exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task rchk(input tsv_addr_t a, input tsv_word_t exp);
      ahb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // Reset values, then all-ones pattern through every register
   task t_regs();
      for (int i = 0; i < 11; i++) rchk(OFS[i], RST[i]);
      for (int i = 0; i < 11; i++) ahb(1'b1, OFS[i], 32'hFFFFFFFF);
      for (int i = 0; i < 11; i++) rchk(OFS[i], MSK[i]);
      chk(stream_attr_byte_a, 32'hFF);
      chk(stream_attr_byte_b, 32'h7);
      chk(clock_ratio_numerator, 32'hFFFFFF);
      chk(clock_ratio_denominator, 32'hFFFFFF);
      chk(transfer_unit_length, 32'h7E);
      chk(lane_word_count, 32'hFFFFFFFF);
      chk({vbid_interlaced, unit_interlaced}, 32'h3);
      chk({unit_fraction_bytes, unit_min_bytes}, 32'h3FFFF);
      ahb(1'b1, TSV_OFF_TU_LEN, 32'h21);
      rchk(TSV_OFF_TU_LEN, 32'h20);
   endtask
   // Asynchronous mode keeps the software value for readback
   task t_async();
      ahb(1'b1, TSV_OFF_ATTR_A, 32'hFE);
      ahb(1'b1, TSV_OFF_RATIO_NUM, 32'h123456);
      rchk(TSV_OFF_RATIO_NUM, 32'h123456);
      rchk(TSV_OFF_RATIO_DEN, 32'hFFFFFF);
   endtask
   // Pixel width codes, an unlisted code falls back to one pixel
   task t_pix();
      logic [2:0] code [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
      logic [2:0] exp [4] = '{3'h1, 3'h2, 3'h4, 3'h1};
      for (int i = 0; i < 4; i++)
      begin
         ahb(1'b1, TSV_OFF_PIX_WIDTH, {29'h0, code[i]});
         @(posedge hclk);
         chk(pixels_per_clock, exp[i]);
      end
   endtask
   // Line start wait of zero, one and three cycles
   task t_wait();
      logic [7:0] dly [3] = '{8'h00, 8'h03, 8'h01};
      for (int i = 0; i < 3; i++)
      begin
         ahb(1'b1, TSV_OFF_LINE_DELAY, {24'h0, dly[i]});
         u_tsv_frame_model.send_line();
         n = 0;
         for (int k = 0; k < 300 && line_wait_done !== 1'b1; k++)
         begin
            @(posedge hclk);
            if (line_wait_active === 1'b1) n++;
         end
         chk(n, dly[i]);
      end
   endtask
   // Lane word counts as software derives them for 1, 2 and 4 lanes
   task t_lane();
      int w;
      w = (1366 * 18 + 15) / 16;
      for (int l = 1; l <= 4; l *= 2)
      begin
         ahb(1'b1, TSV_OFF_LANE_WORDS, w + w % l - l);
         rchk(TSV_OFF_LANE_WORDS, (l == 4) ? 32'h5FE : 32'h600);
      end
      chk(lane_word_count, 32'h5FE);
   endtask
   // Payload table writes land per byte lane; reads and unmapped return zero
   task t_table();
      ahb(1'b1, TSV_TABLE_BASE, 32'h44332211);
      ahb(1'b1, 12'h8FC, 32'hDDCCBBAA);
      for (int k = 0; k < 8; k++)
      begin
         slot_idx <= (k < 4) ? k : 248 + k;
         repeat (2) @(posedge hclk);
         chk(slot_data, (k < 4) ? 8'h11 * (k + 1) : 8'hAA + 8'h11 * (k - 4));
      end
      rchk(TSV_TABLE_BASE, 32'h0);
      ahb(1'b1, 12'h700, 32'hFFFFFFFF);
      rchk(12'h700, 32'h0);
   endtask
   task finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Watchdog well past the expected run length
   initial
   begin
      #(40 * 20000);
      error_cnt++;
      finish_test();
   end
   initial
   begin
      hresetn = 1'b0; hsel = 1'b0; htrans = 2'h0; haddr = '0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = '0; slot_idx = 8'h00;
      error_cnt = 0; cmp_count = 0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_async();
      t_pix();
      t_wait();
      t_lane();
      t_table();
      // Second reset in mid-run restores the unit length
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rchk(TSV_OFF_TU_LEN, 32'h40);
      finish_test();
   end
endmodule

`default_nettype wire
